// >>> capture_model.sv
// Purpose: Data capture logic on the far side of the output word bus
// Assumes: Words qualified by a one-cycle valid pulse, same clock
// Notes:   Never stalls; the output bus has no back-pressure
`timescale 1ns/10ps
module capture_model
  import pattern_gen_pkg::*;
#(
  parameter int DATA_W = 12
)(
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic [DATA_W-1:0] word_i,
  input  wire logic              valid_i,
  output logic      [DATA_W-1:0] word_o,
  output logic                   stb_o
);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stb_o  <= 1'b0;
      word_o <= '0;
    end else begin
      stb_o <= valid_i;
      if (valid_i) begin
        word_o <= word_i;
      end
    end
  end
endmodule : capture_model

// >>> pattern_gen.sv
// Purpose: Output test pattern generator with serial register access
// Assumes: Serial clock far slower than CLOCK_I; pins are asynchronous
// Notes:   Data words are the top DATA_W bits of 16-bit user patterns
//
// Summary of operation
// [RULE1] Test select zero passes conversion data
// [RULE2] Codes 1..3 give midscale, +full, -full
// [RULE3] Code 4 gives alternating-bit checkerboard
// [RULE4] Code 7 toggles all-ones and all-zeros
// [RULE5] Code 8 sends user words per sequencing
// [RULE6] Codes 5, 6, 9..15 are reserved
// [RULE7] Sequencing: single repeats one, alternate swaps
// [RULE8] DDR enable resets zero, small package forced one
// [RULE9] Open three-level pin is a distinct state
// [RULE10] Held in reset until data-out pulled high
// [RULE11] User word is high byte over low byte
`timescale 1ns/10ps
module pattern_gen
  import pattern_gen_pkg::*;
#(
  parameter int         DATA_W        = 12,
  parameter bit         SMALL_PACKAGE = 1'b0
)(
  input  wire logic              CLOCK_I,
  input  wire logic              NRST_I,
  input  wire logic              SCLK_I,
  input  wire logic              CSB_I,
  input  wire logic              SDI_I,
  input  wire logic              SDO_I,
  output logic                   SDO_O,
  output logic                   SDO_OE_O,
  input  wire logic [TRI_PINS-1:0] TRI_HI_I,
  input  wire logic [TRI_PINS-1:0] TRI_LO_I,
  input  wire logic [DATA_W-1:0] CONV_DATA_I,
  input  wire logic              CONV_VALID_I,
  output logic      [DATA_W-1:0] DATA_O,
  output logic                   DATA_VALID_O,
  output logic                   DDR_EN_O,
  output logic [2*TRI_PINS-1:0]  TRI_STATE_O,
  output logic                   CORE_READY_O
);

  typedef enum logic [2:0] {
    SPI_IDLE  = 3'b000,
    SPI_INSTR = 3'b001,
    SPI_WDATA = 3'b010,
    SPI_RDATA = 3'b011,
    SPI_DONE  = 3'b100
  } spi_state_t;

  localparam logic DDR_RESET = SMALL_PACKAGE;

  logic [2:0]   sclk_sync_reg;
  logic [2:0]   csb_sync_reg;
  logic [2:0]   sdi_sync_reg;
  logic [2:0]   sdo_sync_reg;
  logic         sclk_lvl_reg;
  logic         csb_lvl_reg;
  logic         sdi_lvl_reg;
  logic         sdo_lvl_reg;
  logic         sclk_rise;
  spi_state_t   spi_state_reg;
  logic [4:0]   bit_cnt_reg;
  logic [15:0]  shift_reg;
  logic [7:0]   rd_shift_reg;
  logic [12:0]  addr_reg;
  logic         wr_strobe;
  logic [7:0]   wr_byte;
  logic [7:0]   test_select_reg;
  logic [7:0]   pat_one_lo_reg;
  logic [7:0]   pat_one_hi_reg;
  logic [7:0]   pat_two_lo_reg;
  logic [7:0]   pat_two_hi_reg;
  logic         ddr_en_reg;
  logic         ready_reg;
  logic         phase_reg;
  logic [3:0]   test_mode;
  logic [1:0]   user_seq;
  logic [15:0]  pattern_one;
  logic [15:0]  pattern_two;
  logic [DATA_W-1:0] word_next;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [12:0] addr);
    case (addr)
      OFS_OUTPUT_TEST_SELECT: read_reg = test_select_reg;
      OFS_PATTERN_ONE_LOW:    read_reg = pat_one_lo_reg;
      OFS_PATTERN_ONE_HIGH:   read_reg = pat_one_hi_reg;
      OFS_PATTERN_TWO_LOW:    read_reg = pat_two_lo_reg;
      OFS_PATTERN_TWO_HIGH:   read_reg = pat_two_hi_reg;
      OFS_OUTPUT_MODE_B:
        read_reg = 8'(ddr_en_reg) << DDR_ENABLE_BIT;
      default:                read_reg = REG_RESET;
    endcase
  endfunction : read_reg

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sclk_sync_reg <= 3'h0;
      csb_sync_reg  <= 3'h7;
      sdi_sync_reg  <= 3'h0;
      sdo_sync_reg  <= 3'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], SCLK_I};
      csb_sync_reg  <= {csb_sync_reg[1:0], CSB_I};
      sdi_sync_reg  <= {sdi_sync_reg[1:0], SDI_I};
      sdo_sync_reg  <= {sdo_sync_reg[1:0], SDO_I};
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sclk_lvl_reg <= 1'b0;
      csb_lvl_reg  <= 1'b1;
      sdi_lvl_reg  <= 1'b0;
      sdo_lvl_reg  <= 1'b0;
    end else begin
      if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
        sclk_lvl_reg <= sclk_sync_reg[2];
      end
      if (csb_sync_reg[1] == csb_sync_reg[2]) begin
        csb_lvl_reg <= csb_sync_reg[2];
      end
      if (sdi_sync_reg[1] == sdi_sync_reg[2]) begin
        sdi_lvl_reg <= sdi_sync_reg[2];
      end
      if (sdo_sync_reg[1] == sdo_sync_reg[2]) begin
        sdo_lvl_reg <= sdo_sync_reg[2];
      end
    end
  end

  assign sclk_rise = sclk_sync_reg[1] && sclk_sync_reg[2] &&
                     !sclk_lvl_reg;

  // ----------------------------------------------------------------
  // Reset release gate
  // ----------------------------------------------------------------
  // Data-out is released until ready, so only the pull-up lifts it
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ready_reg <= 1'b0;
    end else if (sdo_lvl_reg) begin
      ready_reg <= 1'b1; // [RULE10]
    end
  end

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  // Read bits advance on the rising edge; the sync delay keeps the
  // old bit valid at the master's sampling edge
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      spi_state_reg <= SPI_IDLE;
      bit_cnt_reg   <= 5'h00;
      shift_reg     <= 16'h0000;
      rd_shift_reg  <= 8'h00;
      addr_reg      <= 13'h0000;
    end else if (!ready_reg || csb_lvl_reg) begin
      spi_state_reg <= SPI_IDLE; // [RULE10]
      bit_cnt_reg   <= 5'h00;
    end else begin
      case (spi_state_reg)
        SPI_IDLE: begin
          spi_state_reg <= SPI_INSTR;
        end
        SPI_INSTR: begin
          if (sclk_rise) begin
            shift_reg   <= {shift_reg[14:0], sdi_lvl_reg};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == INSTR_LAST_BIT) begin
              bit_cnt_reg <= 5'h00;
              addr_reg    <= {shift_reg[11:0], sdi_lvl_reg};
              if (shift_reg[INSTR_READ_BIT-1]) begin
                rd_shift_reg  <= read_reg({shift_reg[11:0],
                                           sdi_lvl_reg});
                spi_state_reg <= SPI_RDATA;
              end else begin
                spi_state_reg <= SPI_WDATA;
              end
            end
          end
        end
        SPI_WDATA: begin
          if (sclk_rise) begin
            shift_reg   <= {shift_reg[14:0], sdi_lvl_reg};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == DATA_LAST_BIT) begin
              spi_state_reg <= SPI_DONE;
            end
          end
        end
        SPI_RDATA: begin
          if (sclk_rise) begin
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
            bit_cnt_reg  <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == DATA_LAST_BIT) begin
              spi_state_reg <= SPI_DONE;
            end
          end
        end
        default: begin
          spi_state_reg <= SPI_DONE;
        end
      endcase
    end
  end

  assign wr_strobe = ready_reg && !csb_lvl_reg && sclk_rise &&
                     spi_state_reg == SPI_WDATA &&
                     bit_cnt_reg == DATA_LAST_BIT;
  assign wr_byte   = {shift_reg[6:0], sdi_lvl_reg};

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SDO_O    <= 1'b0;
      SDO_OE_O <= 1'b0;
    end else begin
      SDO_O    <= rd_shift_reg[7];
      SDO_OE_O <= ready_reg && !csb_lvl_reg &&
                  spi_state_reg == SPI_RDATA;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      test_select_reg <= REG_RESET;
      pat_one_lo_reg  <= REG_RESET;
      pat_one_hi_reg  <= REG_RESET;
      pat_two_lo_reg  <= REG_RESET;
      pat_two_hi_reg  <= REG_RESET;
    end else if (wr_strobe) begin
      case (addr_reg)
        OFS_OUTPUT_TEST_SELECT: test_select_reg <= wr_byte; // [RULE1]
        OFS_PATTERN_ONE_LOW:    pat_one_lo_reg  <= wr_byte;
        OFS_PATTERN_ONE_HIGH:   pat_one_hi_reg  <= wr_byte;
        OFS_PATTERN_TWO_LOW:    pat_two_lo_reg  <= wr_byte;
        OFS_PATTERN_TWO_HIGH:   pat_two_hi_reg  <= wr_byte;
        default: ;
      endcase
    end
  end

  // Small package pulls the bit high, so writes cannot clear it
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ddr_en_reg <= DDR_RESET; // [RULE8]
    end else if (SMALL_PACKAGE) begin
      ddr_en_reg <= 1'b1; // [RULE8]
    end else if (wr_strobe && addr_reg == OFS_OUTPUT_MODE_B) begin
      ddr_en_reg <= wr_byte[DDR_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Pattern selection
  // ----------------------------------------------------------------
  assign test_mode   = test_select_reg[TEST_MODE_LSB +: 4];
  assign user_seq    = test_select_reg[USER_SEQ_LSB +: 2];
  assign pattern_one = {pat_one_hi_reg, pat_one_lo_reg}; // [RULE11]
  assign pattern_two = {pat_two_hi_reg, pat_two_lo_reg}; // [RULE11]

  always_comb begin
    case (test_mode)
      TEST_OFF:      word_next = CONV_DATA_I; // [RULE1]
      TEST_MIDSCALE: word_next = {1'b1, {(DATA_W-1){1'b0}}}; // [RULE2]
      TEST_POS_FULL: word_next = {DATA_W{1'b1}}; // [RULE2]
      TEST_NEG_FULL: word_next = {DATA_W{1'b0}}; // [RULE2]
      TEST_CHECKER:
        word_next = {(DATA_W/2){phase_reg, !phase_reg}}; // [RULE3]
      TEST_ONE_ZERO: word_next = {DATA_W{!phase_reg}}; // [RULE4]
      TEST_USER: begin
        // Reserved sequencing codes fall back to single
        if (user_seq == SEQ_ALTERNATE && phase_reg) begin
          word_next = pattern_two[15 -: DATA_W]; // [RULE7]
        end else begin
          word_next = pattern_one[15 -: DATA_W]; // [RULE5]
        end
      end
      default:       word_next = {DATA_W{1'b0}}; // [RULE6]
    endcase
  end

  // Phase advances once per output sample
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      phase_reg    <= 1'b0;
      DATA_O       <= '0;
      DATA_VALID_O <= 1'b0;
    end else begin
      DATA_VALID_O <= ready_reg && CONV_VALID_I; // [RULE10]
      if (ready_reg && CONV_VALID_I) begin
        phase_reg <= !phase_reg;
        DATA_O    <= word_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Three-level pins and status outputs
  // ----------------------------------------------------------------
  tri_pin_if tri_pin [TRI_PINS] ();

  for (genvar g = 0; g < TRI_PINS; g++) begin : g_tri
    tri_level_sampler u_sampler (
      .clk_i  (CLOCK_I),
      .nrst_i (NRST_I),
      .hi_i   (TRI_HI_I[g]),
      .lo_i   (TRI_LO_I[g]),
      .pin    (tri_pin[g])
    );
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        TRI_STATE_O[2*g +: 2] <= PIN_FLOAT;
      end else begin
        TRI_STATE_O[2*g +: 2] <= tri_pin[g].state; // [RULE9]
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      DDR_EN_O     <= DDR_RESET;
      CORE_READY_O <= 1'b0;
    end else begin
      DDR_EN_O     <= ddr_en_reg;
      CORE_READY_O <= ready_reg;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);

  a_normal_pass: assert property ( // [RULE1]
    ready_reg && CONV_VALID_I && test_mode == TEST_OFF
    |=> DATA_VALID_O && DATA_O == $past(CONV_DATA_I))
    else $error("conversion data not passed");
  a_fixed_words: assert property ( // [RULE2]
    ready_reg && CONV_VALID_I &&
    (test_mode == TEST_POS_FULL || test_mode == TEST_NEG_FULL)
    |=> DATA_O == {DATA_W{$past(test_mode) == TEST_POS_FULL}})
    else $error("full-scale word wrong");
  a_midscale_word: assert property ( // [RULE2]
    ready_reg && CONV_VALID_I && test_mode == TEST_MIDSCALE
    |=> DATA_O[DATA_W-1] && DATA_O[DATA_W-2:0] == '0)
    else $error("midscale word wrong");
  a_checker_bits: assert property ( // [RULE3]
    ready_reg && CONV_VALID_I && test_mode == TEST_CHECKER
    |=> DATA_O[0] != DATA_O[1] && DATA_O[1] != DATA_O[2])
    else $error("checkerboard bits not alternating");
  a_toggle_word: assert property ( // [RULE4]
    ready_reg && CONV_VALID_I && test_mode == TEST_ONE_ZERO
    ##1 CONV_VALID_I && test_mode == TEST_ONE_ZERO
    |=> DATA_O == ~$past(DATA_O))
    else $error("one/zero word did not toggle");
  a_user_single: assert property ( // [RULE5]
    ready_reg && CONV_VALID_I && test_mode == TEST_USER &&
    user_seq == SEQ_SINGLE
    |=> DATA_O == $past(pattern_one[15 -: DATA_W]))
    else $error("single user word wrong");
  a_user_alt: assert property ( // [RULE7]
    ready_reg && CONV_VALID_I && test_mode == TEST_USER &&
    user_seq == SEQ_ALTERNATE && phase_reg
    |=> DATA_O == $past(pattern_two[15 -: DATA_W]))
    else $error("alternate user word wrong");
  a_ddr_forced: assert property ( // [RULE8]
    SMALL_PACKAGE |-> DDR_EN_O)
    else $error("DDR enable not forced");
  a_tri_open: assert property ( // [RULE9]
    (!TRI_HI_I[0] && !TRI_LO_I[0])[*6] |=> TRI_STATE_O[1:0] == PIN_FLOAT)
    else $error("open pin not decoded");
  a_held_reset: assert property ( // [RULE10]
    !ready_reg |=> !DATA_VALID_O && !SDO_OE_O)
    else $error("active while held in reset");

  c_user_alt: cover property (
    DATA_VALID_O && test_mode == TEST_USER && user_seq == SEQ_ALTERNATE);
  c_reg_write: cover property (wr_strobe);
  c_reg_read: cover property (SDO_OE_O);
  c_ready: cover property ($rose(ready_reg));

endmodule : pattern_gen

// >>> pattern_gen_pkg.sv
// Purpose: Shared constants for the output test pattern generator
// Assumes: 8-bit serial configuration registers, 50 MHz core clock
// Notes:   Pin states are two-bit codes shared with the pin sampler
package pattern_gen_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [12:0] OFS_OUTPUT_TEST_SELECT  = 13'h00c0;
  localparam logic [12:0] OFS_RESERVED_C1         = 13'h00c1;
  localparam logic [12:0] OFS_PATTERN_ONE_LOW     = 13'h00c2;
  localparam logic [12:0] OFS_PATTERN_ONE_HIGH    = 13'h00c3;
  localparam logic [12:0] OFS_PATTERN_TWO_LOW     = 13'h00c4;
  localparam logic [12:0] OFS_PATTERN_TWO_HIGH    = 13'h00c5;
  localparam logic [12:0] OFS_OUTPUT_MODE_B       = 13'h0074;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          TEST_MODE_LSB   = 0;
  localparam int          USER_SEQ_LSB    = 6;
  localparam int          DDR_ENABLE_BIT  = 4;
  localparam logic [7:0]  REG_RESET       = 8'h00;

  // Output test selection codes
  localparam logic [3:0]  TEST_OFF        = 4'h0;
  localparam logic [3:0]  TEST_MIDSCALE   = 4'h1;
  localparam logic [3:0]  TEST_POS_FULL   = 4'h2;
  localparam logic [3:0]  TEST_NEG_FULL   = 4'h3;
  localparam logic [3:0]  TEST_CHECKER    = 4'h4;
  localparam logic [3:0]  TEST_ONE_ZERO   = 4'h7;
  localparam logic [3:0]  TEST_USER       = 4'h8;

  // User pattern sequencing codes
  localparam logic [1:0]  SEQ_SINGLE      = 2'h0;
  localparam logic [1:0]  SEQ_ALTERNATE   = 2'h1;

  // ----------------------------------------------------------------
  // Serial port framing
  // ----------------------------------------------------------------
  localparam logic [4:0]  INSTR_LAST_BIT  = 5'h0f;
  localparam logic [4:0]  DATA_LAST_BIT   = 5'h07;
  localparam int          INSTR_READ_BIT  = 15;

  // Three-level pin states and pin count
  localparam logic [1:0]  PIN_LOW         = 2'h0;
  localparam logic [1:0]  PIN_FLOAT       = 2'h1;
  localparam logic [1:0]  PIN_HIGH        = 2'h2;
  localparam int          TRI_PINS        = 4;

endpackage : pattern_gen_pkg

// >>> pattern_gen_tb.sv
// Purpose: Self-checking bench for the output test pattern generator
// Assumes: Serial half period of 10 core cycles, pull-up on data out
// Notes:   Driver queues expected words, monitor compares captures
`timescale 1ns/10ps
module pattern_gen_tb
  import pattern_gen_pkg::*;
;
  localparam int DW = 12;
  logic            clk = 1'b0, nrst = 1'b0, sclk = 1'b0, csb = 1'b1;
  logic            sdi = 1'b0, pull_on = 1'b0, cv = 1'b0;
  logic [3:0]      thi = 4'h0, tlo = 4'h0;
  logic [DW-1:0]   cdat = '0, dout, cw;
  logic            serial_data_output, sdo_oe, dvalid, ddr, ready, cs;
  logic [7:0]      tstate;
  wire             sdo_wire = sdo_oe ? serial_data_output : pull_on;
  logic [DW-1:0]   exp_q[$];
  logic [31:0]     seed = 32'd65847;
  logic [15:0]     p1, p2;
  logic [3:0]      mode_m = TEST_OFF;
  logic [1:0]      seq_m = SEQ_SINGLE;
  logic [7:0]      rd;
  bit              ph = 1'b0;
  int              err_total = 0, check_count = 0;
  logic [3:0]      modes[5] = '{TEST_MIDSCALE, TEST_POS_FULL,
                                TEST_NEG_FULL, TEST_CHECKER, TEST_ONE_ZERO};

  always #10 clk = ~clk;

  pattern_gen #(.DATA_W(DW), .SMALL_PACKAGE(1'b0)) uut (
    .CLOCK_I(clk), .NRST_I(nrst), .SCLK_I(sclk), .CSB_I(csb),
    .SDI_I(sdi), .SDO_I(sdo_wire), .SDO_O(serial_data_output), .SDO_OE_O(sdo_oe),
    .TRI_HI_I(thi), .TRI_LO_I(tlo), .CONV_DATA_I(cdat),
    .CONV_VALID_I(cv), .DATA_O(dout), .DATA_VALID_O(dvalid),
    .DDR_EN_O(ddr), .TRI_STATE_O(tstate), .CORE_READY_O(ready));

  capture_model #(.DATA_W(DW)) cap (
    .clk_i(clk), .nrst_i(nrst), .word_i(dout), .valid_i(dvalid),
    .word_o(cw), .stb_o(cs));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Frame: read flag, two ignored bits, 13-bit address, data byte
  task automatic spi(input logic r, input logic [12:0] a,
                     input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] fr;
    fr = {r, 2'b00, a, wd};
    q = 8'h00;
    tick(1);
    csb = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = fr[i];
      tick(10);
      if (i < 8) q[i] = serial_data_output;
      if (i < 8) chk("sdo_oe", 16'(sdo_oe), 16'(r));
      sclk = 1'b1;
      tick(10);
      sclk = 1'b0;
    end
    tick(10);
    csb = 1'b1;
    tick(6);
  endtask : spi

  function automatic logic [DW-1:0] want(logic [DW-1:0] c);
    case (mode_m)
      TEST_OFF:      want = c;
      TEST_MIDSCALE: want = 12'h800;
      TEST_POS_FULL: want = 12'hfff;
      TEST_NEG_FULL: want = 12'h000;
      TEST_CHECKER:  want = ph ? 12'haaa : 12'h555;
      TEST_ONE_ZERO: want = ph ? 12'h000 : 12'hfff;
      TEST_USER:     want = (seq_m == SEQ_ALTERNATE && ph) ?
                            p2[15:4] : p1[15:4];
      default:       want = 12'h000;
    endcase
  endfunction : want

  // Back-to-back samples; phase advances on every taken sample
  task automatic feed(input int n);
    for (int i = 0; i < n; i++) begin
      cdat = DW'(rnd());
      cv = 1'b1;
      exp_q.push_back(want(cdat));
      ph = ~ph;
      tick(1);
    end
    cv = 1'b0;
    tick(4);
  endtask : feed

  task automatic set_mode(input logic [3:0] m, input logic [1:0] s);
    spi(1'b0, OFS_OUTPUT_TEST_SELECT, {s, 2'b00, m}, rd);
    mode_m = m;
    seq_m = s;
  endtask : set_mode

  // ------------------------------------------------------------
  // Monitor and watchdog
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (cs === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("BAD word expected none seen %h", cw);
      end else begin
        chk("w", 16'(cw), 16'(exp_q.pop_front()));
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("BAD watchdog expected finish seen hang");
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    tick(10);
    nrst = 1'b1;
    cv = 1'b1;
    tick(30);
    cv = 1'b0;
    // Write while held must be ignored; read back below as zero
    spi(1'b0, OFS_OUTPUT_TEST_SELECT, 8'h01, rd);
    chk("ready_held", 16'(ready), 16'h0);
    pull_on = 1'b1;
    tick(10);
    chk("ready", 16'(ready), 16'h1);
    $display("test held_reset done");

    for (int a = 'hc0; a <= 'hc6; a++) begin
      spi(1'b1, 13'(a), 8'h00, rd);
      chk("reg_reset", 16'(rd), 16'h0);
    end
    spi(1'b0, OFS_RESERVED_C1, 8'hff, rd);
    spi(1'b1, OFS_RESERVED_C1, 8'h00, rd);
    chk("reserved", 16'(rd), 16'h0);
    spi(1'b1, OFS_OUTPUT_MODE_B, 8'h00, rd);
    chk("ddr_reg", 16'(rd), 16'h0);
    chk("ddr_pin", 16'(ddr), 16'h0);
    spi(1'b0, OFS_OUTPUT_MODE_B, 8'h10, rd);
    chk("ddr_set", 16'(ddr), 16'h1);
    $display("test registers done");

    // Pin codes: 0 low, 1 open, 2 high, 3 both comparators set
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) begin
        thi[i] = ((i + k) % 4) >= 2;
        tlo[i] = ((i + k) % 4) == 0 || ((i + k) % 4) == 3;
      end
      tick(8);
      for (int i = 0; i < 4; i++) begin
        chk("pin", 16'(tstate[2*i+:2]),
            16'(((i + k) % 4) == 0 ? 0 : ((i + k) % 4) == 2 ? 2 : 1));
      end
    end
    $display("test pins done");

    feed(5);
    foreach (modes[j]) begin
      set_mode(modes[j], SEQ_SINGLE);
      feed(5);
    end
    $display("test fixed patterns done");

    p1 = 16'(rnd());
    p2 = 16'(rnd());
    spi(1'b0, OFS_PATTERN_ONE_LOW, p1[7:0], rd);
    spi(1'b0, OFS_PATTERN_ONE_HIGH, p1[15:8], rd);
    spi(1'b0, OFS_PATTERN_TWO_LOW, p2[7:0], rd);
    spi(1'b0, OFS_PATTERN_TWO_HIGH, p2[15:8], rd);
    spi(1'b1, OFS_PATTERN_TWO_HIGH, 8'h00, rd);
    chk("pat_read", 16'(rd), 16'(p2[15:8]));
    set_mode(TEST_USER, SEQ_SINGLE);
    feed(3);
    set_mode(TEST_USER, SEQ_ALTERNATE);
    feed(5);
    set_mode(TEST_OFF, SEQ_SINGLE);
    feed(2);
    $display("test user patterns done");

    tick(5);
    chk("left", 16'(exp_q.size()), 16'h0);
    report_and_stop();
  end
endmodule : pattern_gen_tb

// >>> tri_level_sampler.sv
// Purpose: Synchronises and decodes one three-level configuration pin
// Assumes: Pin front end gives a high and a low comparator level
// Notes:   Neither level asserted means the pin is left open
`timescale 1ns/10ps
module tri_level_sampler
  import pattern_gen_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic hi_i,
  input  wire logic lo_i,
  tri_pin_if.src    pin
);

  logic [2:0] hi_sync_reg;
  logic [2:0] lo_sync_reg;
  logic [1:0] raw_state;

  // ----------------------------------------------------------------
  // Three-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_sync_reg <= 3'h0;
      lo_sync_reg <= 3'h0;
    end else begin
      hi_sync_reg <= {hi_sync_reg[1:0], hi_i};
      lo_sync_reg <= {lo_sync_reg[1:0], lo_i};
    end
  end

  // Open pin is its own valid choice, not a fault
  always_comb begin
    if (hi_sync_reg[2] && !lo_sync_reg[2]) begin
      raw_state = PIN_HIGH;
    end else if (lo_sync_reg[2] && !hi_sync_reg[2]) begin
      raw_state = PIN_LOW;
    end else begin
      raw_state = PIN_FLOAT; // [RULE9]
    end
  end

  // Accept only once stages two and three agree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin.state <= PIN_FLOAT;
    end else if (hi_sync_reg[1] == hi_sync_reg[2] &&
                 lo_sync_reg[1] == lo_sync_reg[2]) begin
      pin.state <= raw_state; // [RULE9]
    end
  end

endmodule : tri_level_sampler

// >>> tri_pin_if.sv
// Purpose: Carries one decoded three-level pin state
// Assumes: State codes from pattern_gen_pkg
// Notes:   Sampler drives, generator reads
`timescale 1ns/10ps
interface tri_pin_if;
  logic [1:0] state;
  modport src (output state);
  modport dst (input  state);
endinterface : tri_pin_if
